/* design/wdr_pkg.sv */
package wdr_pkg;

   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int IDX_W = 8;
   localparam int BE_W = 4;
   localparam logic [1:0] ADDR_ALIGN = 2'h0;

   // ----------------------------------------------------------------
   // register indices, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_COMMAND = 8'hC0;
   localparam logic [IDX_W-1:0] IDX_CONTROL_HIGH = 8'hC1;
   localparam logic [IDX_W-1:0] IDX_COUNT_HIGH = 8'hC2;
   localparam logic [IDX_W-1:0] IDX_COUNT_LOW = 8'hC3;
   localparam logic [IDX_W-1:0] IDX_FLAGS = 8'hC4;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'hC5;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 8'hC6;
   localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 8'hC7;

   // ----------------------------------------------------------------
   // field layout
   // ----------------------------------------------------------------
   localparam int CMD_RELOAD_BIT = 0;
   localparam int CMD_STOP_BIT = 1;
   localparam int CTRL_DISABLE_BIT = 0;
   localparam int SEL_LSB = 4;
   localparam int SEL_W = 3;
   localparam logic [SEL_W-1:0] SEL_RESET = 3'h7;
   localparam int FLAG_W = 2;
   localparam int FLAG_SREC_BIT = 0;
   localparam int FLAG_SUP_BIT = 1;
   localparam int IRQ_W = 2;
   localparam int IRQ_TIMEOUT_BIT = 0;
   localparam int IRQ_STOP_BIT = 1;

   // ----------------------------------------------------------------
   // counter and prescaler
   // ----------------------------------------------------------------
   localparam int PRESCALE_W = 6;
   localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = 6'h3F;
   localparam int COUNT_W = 16;
   localparam int BYTE_W = 8;
   localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
   localparam logic [COUNT_W-SEL_W-1:0] SEL_FILL = 13'h1FFF;
   localparam logic [COUNT_W-1:0] VECTOR_ADDR = 16'h0020;

   typedef enum logic [0:0] {WDR_RUN, WDR_STOP} wdr_mode_e;

   // reload value chosen by the timeout select field
   function automatic logic [COUNT_W-1:0] wdr_init_value(input logic [SEL_W-1:0] sel);
      wdr_init_value = {sel, SEL_FILL};
   endfunction

endpackage

/* design/wdr_prescale.sv */
`timescale 1ns/1ps
module wdr_prescale
   import wdr_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // control
   input wire logic run_in,
   input wire logic restart_in,
   // enable pulse
   output logic tick_out
);

   // ----------------------------------------------------------------
   // divide by sixty-four
   // ----------------------------------------------------------------
   logic [PRESCALE_W-1:0] div_reg;
   logic [PRESCALE_W-1:0] gap_reg;
   logic seen_reg;

   // phase counter, frozen while not running
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         div_reg <= '0;
         tick_out <= 1'b0;
      end
      else if (restart_in)
      begin
         div_reg <= '0;
         tick_out <= 1'b0;
      end
      else
      begin
         if (run_in)
         begin
            div_reg <= div_reg + 1'b1;
         end
         tick_out <= run_in && (div_reg == PRESCALE_LAST);
      end
   end

   // helper for the spacing check
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         gap_reg <= '0;
         seen_reg <= 1'b0;
      end
      else if (restart_in || !run_in)
      begin
         gap_reg <= '0;
         seen_reg <= 1'b0;
      end
      else if (tick_out)
      begin
         gap_reg <= '0;
         seen_reg <= 1'b1;
      end
      else
      begin
         gap_reg <= gap_reg + 1'b1;
      end
   end

   property p_tick_spacing;
      @(posedge clk_in) disable iff (!rstn_in)
      (tick_out && seen_reg && run_in && !restart_in) |-> (gap_reg == PRESCALE_LAST);
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("tick spacing is not 64 cycles");

endmodule

/* design/wdr_top.sv */
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
module wdr_top
   import wdr_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [DATA_W-1:0] avs_writedata_in,
   input wire logic [BE_W-1:0] avs_byteenable_in,
   output logic [DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // device events
   input wire logic reset_pin_in,
   input wire logic stop_wake_in,
   // core side
   output logic vector_load_out,
   output logic [COUNT_W-1:0] vector_addr_out,
   output logic sup_reset_out,
   output logic stop_mode_out,
   output logic irq_out
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   wdr_mode_e mode_reg;
   wdr_mode_e mode_next;
   logic [COUNT_W-1:0] count_reg;
   logic [SEL_W-1:0] sel_reg;
   logic sup_en_reg;
   logic window_reg;
   logic [FLAG_W-1:0] flags_reg;
   logic [IRQ_W-1:0] irq_status_reg;
   logic [IRQ_W-1:0] irq_enable_reg;
   logic [DATA_W-1:0] rd_mux;
   logic req;
   logic acc;
   logic wr_acc;
   logic be0;
   logic tick;
   logic running;
   logic timeout;
   logic reload_cmd;
   logic stop_cmd;
   logic ctrl_wr;
   logic flag_wr;
   logic irq_clr_wr;
   logic irq_en_wr;

   // address match on an aligned word
   function automatic logic wdr_hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
      wdr_hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == ADDR_ALIGN);
   endfunction

   // ----------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------

   // request is taken on the cycle waitrequest is low
   assign req = avs_read_in || avs_write_in;
   assign acc = req && !avs_waitrequest_out;
   assign wr_acc = acc && avs_write_in;
   assign be0 = avs_byteenable_in[0];

   // one wait cycle per access
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         avs_waitrequest_out <= 1'b1;
      end
      else
      begin
         avs_waitrequest_out <= !(req && avs_waitrequest_out);
      end
   end

   // read mux, unmapped reads give zero
   always_comb
   begin
      rd_mux = '0;
      if (wdr_hit(avs_address_in, IDX_CONTROL_HIGH))
      begin
         rd_mux[SEL_LSB +: SEL_W] = sel_reg;
         rd_mux[CTRL_DISABLE_BIT] = !sup_en_reg;
      end
      else if (wdr_hit(avs_address_in, IDX_COUNT_HIGH))
      begin
         rd_mux[BYTE_W-1:0] = count_reg[COUNT_W-1:BYTE_W];
      end
      else if (wdr_hit(avs_address_in, IDX_COUNT_LOW))
      begin
         rd_mux[BYTE_W-1:0] = count_reg[BYTE_W-1:0];
      end
      else if (wdr_hit(avs_address_in, IDX_FLAGS))
      begin
         rd_mux[FLAG_W-1:0] = flags_reg;
      end
      else if (wdr_hit(avs_address_in, IDX_IRQ_STATUS))
      begin
         rd_mux[IRQ_W-1:0] = irq_status_reg;
      end
      else if (wdr_hit(avs_address_in, IDX_IRQ_ENABLE))
      begin
         rd_mux[IRQ_W-1:0] = irq_enable_reg;
      end
      else
      begin
         rd_mux = '0;
      end
   end

   // read data captured during the wait cycle
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         avs_readdata_out <= '0;
      end
      else if (avs_read_in && avs_waitrequest_out)
      begin
         avs_readdata_out <= rd_mux;
      end
   end

   // write strobes
   // reload only in run mode, so stop mode keeps the count frozen
   assign reload_cmd = wr_acc && be0 && wdr_hit(avs_address_in, IDX_COMMAND) && avs_writedata_in[CMD_RELOAD_BIT]
                       && (mode_reg == WDR_RUN);
   assign stop_cmd = wr_acc && be0 && wdr_hit(avs_address_in, IDX_COMMAND) && avs_writedata_in[CMD_STOP_BIT]
                     && (mode_reg == WDR_RUN);
   assign ctrl_wr = wr_acc && be0 && wdr_hit(avs_address_in, IDX_CONTROL_HIGH);
   assign flag_wr = wr_acc && be0 && wdr_hit(avs_address_in, IDX_FLAGS);
   assign irq_clr_wr = wr_acc && be0 && wdr_hit(avs_address_in, IDX_IRQ_CLEAR);
   assign irq_en_wr = wr_acc && be0 && wdr_hit(avs_address_in, IDX_IRQ_ENABLE);

   // ----------------------------------------------------------------
   // mode and control
   // ----------------------------------------------------------------

   // run or stop
   always_comb
   begin
      mode_next = mode_reg;
      case (mode_reg)
         WDR_RUN:
         begin
            if (stop_cmd && !reset_pin_in)
            begin
               mode_next = WDR_STOP;
            end
         end
         WDR_STOP:
         begin
            if (stop_wake_in || reset_pin_in)
            begin
               mode_next = WDR_RUN;
            end
         end
         default:
         begin
            mode_next = WDR_RUN;
         end
      endcase
   end

   // mode register and its output copy
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         mode_reg <= WDR_RUN;
         stop_mode_out <= 1'b0;
      end
      else
      begin
         mode_reg <= mode_next;
         stop_mode_out <= (mode_next == WDR_STOP);
      end
   end

   // control: select and enable, first access window
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         sel_reg <= SEL_RESET;
         sup_en_reg <= 1'b1;
         window_reg <= 1'b1;
      end
      else if (reset_pin_in)
      begin
         sel_reg <= SEL_RESET;
         sup_en_reg <= 1'b1;
         window_reg <= 1'b1;
      end
      else
      begin
         if (ctrl_wr)
         begin
            sel_reg <= avs_writedata_in[SEL_LSB +: SEL_W];
         end
         if (ctrl_wr && window_reg && avs_writedata_in[CTRL_DISABLE_BIT])
         begin
            sup_en_reg <= 1'b0;
         end
         if (acc)
         begin
            window_reg <= 1'b0;
         end
      end
   end

   property p_enable_locked;
      @(posedge clk_in) disable iff (!rstn_in)
      (!window_reg && !reset_pin_in) |=> $stable(sup_en_reg);
   endproperty
   a_enable_locked: assert property (p_enable_locked) else $error("enable changed after first access");

   // ----------------------------------------------------------------
   // supervision counter
   // ----------------------------------------------------------------

   assign running = sup_en_reg && (mode_reg == WDR_RUN);

   wdr_prescale u_prescale (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .run_in(running),
      .restart_in(reset_pin_in),
      .tick_out(tick)
   );

   // terminal when next value is zero
   assign timeout = tick && running && (count_reg == COUNT_ONE);

   // down counter
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         count_reg <= COUNT_MAX;
      end
      else if (reset_pin_in)
      begin
         count_reg <= COUNT_MAX;
      end
      else if (timeout || reload_cmd || (stop_wake_in && mode_reg == WDR_STOP))
      begin
         count_reg <= wdr_init_value(sel_reg);
      end
      else if (tick && running)
      begin
         count_reg <= count_reg - 1'b1;
      end
   end

   // timeout outputs
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         vector_load_out <= 1'b0;
         vector_addr_out <= '0;
         sup_reset_out <= 1'b0;
      end
      else
      begin
         vector_load_out <= timeout;
         vector_addr_out <= VECTOR_ADDR;
         sup_reset_out <= timeout;
      end
   end

   property p_timeout_vector;
      @(posedge clk_in) disable iff (!rstn_in)
      timeout |=> (vector_load_out && sup_reset_out && vector_addr_out == VECTOR_ADDR);
   endproperty
   a_timeout_vector: assert property (p_timeout_vector) else $error("timeout gave no vector");

   property p_timeout_priority;
      @(posedge clk_in) disable iff (!rstn_in)
      (timeout && reload_cmd) |=> (sup_reset_out && flags_reg[FLAG_SUP_BIT]);
   endproperty
   a_timeout_priority: assert property (p_timeout_priority) else $error("reload masked a timeout");

   property p_reload_value;
      @(posedge clk_in) disable iff (!rstn_in)
      (reload_cmd && !reset_pin_in) |=> (count_reg == wdr_init_value($past(sel_reg)));
   endproperty
   a_reload_value: assert property (p_reload_value) else $error("reload loaded wrong value");

   property p_count_step;
      @(posedge clk_in) disable iff (!rstn_in)
      (tick && running && !timeout && !reload_cmd && !reset_pin_in) |=> (count_reg == $past(count_reg) - 1'b1);
   endproperty
   a_count_step: assert property (p_count_step) else $error("counter did not step down");

   property p_stop_frozen;
      @(posedge clk_in) disable iff (!rstn_in)
      (mode_reg == WDR_STOP && !stop_wake_in && !reset_pin_in) |=> $stable(count_reg);
   endproperty
   a_stop_frozen: assert property (p_stop_frozen) else $error("counter moved in stop mode");

   // ----------------------------------------------------------------
   // reset source flags
   // ----------------------------------------------------------------

   // set wins over clear; write one to clear
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         flags_reg <= '0;
      end
      else
      begin
         flags_reg[FLAG_SUP_BIT] <= timeout || (flags_reg[FLAG_SUP_BIT] && !reset_pin_in
                                    && !(flag_wr && avs_writedata_in[FLAG_SUP_BIT]));
         flags_reg[FLAG_SREC_BIT] <= stop_cmd || (flags_reg[FLAG_SREC_BIT] && !reset_pin_in
                                     && !(flag_wr && avs_writedata_in[FLAG_SREC_BIT]));
      end
   end

   property p_pin_clears;
      @(posedge clk_in) disable iff (!rstn_in)
      (reset_pin_in && !timeout && !stop_cmd) |=> (flags_reg == '0);
   endproperty
   a_pin_clears: assert property (p_pin_clears) else $error("pin reset left a flag set");

   property p_stop_sets;
      @(posedge clk_in) disable iff (!rstn_in)
      (stop_cmd && !reset_pin_in) |=> (flags_reg[FLAG_SREC_BIT] && mode_reg == WDR_STOP && stop_mode_out);
   endproperty
   a_stop_sets: assert property (p_stop_sets) else $error("stop did not set recovery flag");

   property p_read_keeps;
      @(posedge clk_in) disable iff (!rstn_in)
      (acc && avs_read_in && !timeout && !stop_cmd && !reset_pin_in) |=> $stable(flags_reg);
   endproperty
   a_read_keeps: assert property (p_read_keeps) else $error("read changed the flags");

   // ----------------------------------------------------------------
   // interrupt
   // ----------------------------------------------------------------

   // sticky status, enable, level output
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         irq_status_reg <= '0;
         irq_enable_reg <= '0;
         irq_out <= 1'b0;
      end
      else
      begin
         irq_status_reg[IRQ_TIMEOUT_BIT] <= timeout || (irq_status_reg[IRQ_TIMEOUT_BIT]
                                            && !(irq_clr_wr && avs_writedata_in[IRQ_TIMEOUT_BIT]));
         irq_status_reg[IRQ_STOP_BIT] <= stop_cmd || (irq_status_reg[IRQ_STOP_BIT]
                                         && !(irq_clr_wr && avs_writedata_in[IRQ_STOP_BIT]));
         if (irq_en_wr)
         begin
            irq_enable_reg <= avs_writedata_in[IRQ_W-1:0];
         end
         irq_out <= |(irq_status_reg & irq_enable_reg);
      end
   end

endmodule

/* verification/wdr_top_tb_top.sv */
`timescale 1ns/1ps
module wdr_top_tb_top
   import wdr_pkg::*;
   ;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic clk_in;
   logic rstn_in;
   logic [ADDR_W-1:0] avs_address_in;
   logic avs_read_in;
   logic avs_write_in;
   logic [DATA_W-1:0] avs_writedata_in;
   logic [BE_W-1:0] avs_byteenable_in;
   logic [DATA_W-1:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic reset_pin_in;
   logic stop_wake_in;
   logic vector_load_out;
   logic [COUNT_W-1:0] vector_addr_out;
   logic sup_reset_out;
   logic stop_mode_out;
   logic irq_out;
   logic [DATA_W-1:0] q;
   logic [DATA_W-1:0] q0;
   logic pulse_seen;
   int error_cnt;
   int checks;

   // device under test
   wdr_top u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .reset_pin_in(reset_pin_in), .stop_wake_in(stop_wake_in),
      .vector_load_out(vector_load_out), .vector_addr_out(vector_addr_out), .sup_reset_out(sup_reset_out),
      .stop_mode_out(stop_mode_out), .irq_out(irq_out));

   // sticky record of any vector or reset pulse
   always @(posedge clk_in)
   begin
      if (!rstn_in)
         pulse_seen <= 1'b0;
      else if (vector_load_out || sup_reset_out)
         pulse_seen <= 1'b1;
   end

   // 10 mhz clock
   initial
   begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   // ----------------------------------------------------------------
   // bus and compare tasks
   // ----------------------------------------------------------------
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic [IDX_W-1:0] idx, input logic wr, input logic [7:0] d,
      input logic [BE_W-1:0] be, output logic [DATA_W-1:0] rdata);
      int n;
      n = 0;
      avs_address_in <= {idx, ADDR_ALIGN};
      avs_read_in <= ~wr;
      avs_write_in <= wr;
      avs_writedata_in <= {24'h00_0000, d};
      avs_byteenable_in <= be;
      do
      begin
         @(posedge clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 20);
      if (n >= 20)
      begin
         error_cnt++;
         $display("FAIL t=%0t bus access never answered", $time);
      end
      rdata = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
      logic [DATA_W-1:0] dummy;
      bus(idx, 1'b1, d, 4'hF, dummy);
   endtask

   task automatic rd(input logic [IDX_W-1:0] idx, output logic [DATA_W-1:0] rdata);
      bus(idx, 1'b0, 8'h00, 4'hF, rdata);
   endtask

   // one-cycle pulse on the pin reset or the stop wake input
   task automatic pulse(input logic wake);
      if (wake)
         stop_wake_in <= 1'b1;
      else
         reset_pin_in <= 1'b1;
      @(posedge clk_in);
      stop_wake_in <= 1'b0;
      reset_pin_in <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      checks++;
      if ((got >= lo) !== 1'b1 || (got <= hi) !== 1'b1)
      begin
         error_cnt++;
         $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // watchdog against a hung run, tests need about 1.4k cycles
   initial
   begin
      #(50_000 * 100);
      error_cnt++;
      tally_and_finish();
   end

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial
   begin
      error_cnt = 0;
      checks = 0;
      rstn_in = 1'b0;
      avs_address_in = '0;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = '0;
      avs_byteenable_in = '0;
      reset_pin_in = 1'b0;
      stop_wake_in = 1'b0;
      repeat (8) @(posedge clk_in);
      rstn_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      chk({16'h0000, vector_addr_out}, 32'h0000_0020);
      chk({30'h0000_0000, irq_out, stop_mode_out}, 32'h0000_0000);
      // disable taken as the first access, counter then frozen
      wr(IDX_CONTROL_HIGH, 8'h71);
      rd(IDX_CONTROL_HIGH, q);
      chk(q, 32'h0000_0071);
      rd(IDX_COUNT_HIGH, q);
      chk(q, 32'h0000_00FF);
      repeat (200) @(posedge clk_in);
      rd(IDX_COUNT_LOW, q);
      chk(q, 32'h0000_00FF);
      // pin reset reopens the window and re-enables the counter
      pulse(1'b0);
      rd(IDX_CONTROL_HIGH, q);
      chk(q, 32'h0000_0070);
      rd(IDX_FLAGS, q);
      chk(q, 32'h0000_0000);
      wr(IDX_CONTROL_HIGH, 8'h71);
      rd(IDX_CONTROL_HIGH, q);
      chk(q, 32'h0000_0070);
      repeat (300) @(posedge clk_in);
      rd(IDX_COUNT_LOW, q);
      chk_rng(q, 32'h0000_00F9, 32'h0000_00FD);
      // reload value for every select code
      for (int s = 0; s < 8; s++)
      begin
         wr(IDX_CONTROL_HIGH, {1'b0, s[2:0], 4'h0});
         wr(IDX_COMMAND, 8'h01);
         rd(IDX_COUNT_HIGH, q);
         chk(q, {24'h00_0000, s[2:0], 5'h1F});
      end
      // count down rate from a reload with select 0
      wr(IDX_CONTROL_HIGH, 8'h00);
      wr(IDX_COMMAND, 8'h01);
      repeat (512) @(posedge clk_in);
      rd(IDX_COUNT_LOW, q);
      chk_rng(q, 32'h0000_00F5, 32'h0000_00F8);
      rd(IDX_COUNT_HIGH, q);
      chk(q, 32'h0000_001F);
      // unmapped address and disabled byte lane
      rd(8'h10, q);
      chk(q, 32'h0000_0000);
      bus(IDX_CONTROL_HIGH, 1'b1, 8'h50, 4'h0, q);
      rd(IDX_CONTROL_HIGH, q);
      chk(q, 32'h0000_0000);
      // stop sets the recovery flag and raises the stop interrupt
      wr(IDX_IRQ_ENABLE, 8'h02);
      wr(IDX_COMMAND, 8'h02);
      chk({31'h0000_0000, stop_mode_out}, 32'h0000_0001);
      repeat (2) @(posedge clk_in);
      chk({31'h0000_0000, irq_out}, 32'h0000_0001);
      rd(IDX_FLAGS, q);
      chk(q, 32'h0000_0001);
      rd(IDX_FLAGS, q);
      chk(q, 32'h0000_0001);
      rd(IDX_IRQ_STATUS, q);
      chk(q, 32'h0000_0002);
      rd(IDX_COUNT_LOW, q0);
      repeat (200) @(posedge clk_in);
      rd(IDX_COUNT_LOW, q);
      chk(q, q0);
      // mask, unmask and clear the interrupt
      wr(IDX_IRQ_ENABLE, 8'h00);
      repeat (2) @(posedge clk_in);
      chk({31'h0000_0000, irq_out}, 32'h0000_0000);
      wr(IDX_IRQ_ENABLE, 8'h02);
      repeat (2) @(posedge clk_in);
      chk({31'h0000_0000, irq_out}, 32'h0000_0001);
      wr(IDX_IRQ_CLEAR, 8'h02);
      repeat (2) @(posedge clk_in);
      chk({31'h0000_0000, irq_out}, 32'h0000_0000);
      rd(IDX_IRQ_STATUS, q);
      chk(q, 32'h0000_0000);
      // wake leaves stop mode and reloads the counter
      pulse(1'b1);
      chk({31'h0000_0000, stop_mode_out}, 32'h0000_0000);
      rd(IDX_COUNT_HIGH, q);
      chk(q, 32'h0000_001F);
      // software clear of the recovery flag
      wr(IDX_FLAGS, 8'h01);
      rd(IDX_FLAGS, q);
      chk(q, 32'h0000_0000);
      // pin reset clears a set recovery flag
      wr(IDX_COMMAND, 8'h02);
      rd(IDX_FLAGS, q);
      chk(q, 32'h0000_0001);
      pulse(1'b0);
      rd(IDX_FLAGS, q);
      chk(q, 32'h0000_0000);
      chk({31'h0000_0000, stop_mode_out}, 32'h0000_0000);
      // reloads kept the count far from zero, so no timeout pulse
      chk({31'h0000_0000, pulse_seen}, 32'h0000_0000);
      chk({31'h0000_0000, sup_reset_out}, 32'h0000_0000);
      chk({31'h0000_0000, vector_load_out}, 32'h0000_0000);
      tally_and_finish();
   end
endmodule
